// File: verilog/an_regs_pkg.sv
`default_nettype none
package an_regs_pkg;
   // ***********************************************
   // Register indices; byte address is index times four
   // ***********************************************
   localparam logic [5:0] idx_partner_base_page_ability = 6'h05;
   localparam logic [5:0] idx_autoneg_expansion_status = 6'h06;
   localparam logic [5:0] idx_next_page_transmit = 6'h07;
   localparam logic [5:0] idx_next_page_receive = 6'h08;
   localparam logic [5:0] idx_irq_status = 6'h20;
   localparam logic [5:0] idx_irq_mask = 6'h21;

   // ***********************************************
   // Partner base page ability fields
   // ***********************************************
   localparam int lp_hd100_bit = 7;
   localparam int lp_fd10_bit = 6;
   localparam int lp_hd10_bit = 5;
   localparam int lp_np_bit = 15;
   localparam logic [7:0] lp_ability_reset = 8'h01;

   // ***********************************************
   // Expansion status fields
   // ***********************************************
   localparam int exp_loc_able_bit = 6;
   localparam int exp_loc_store_bit = 5;
   localparam int exp_pd_fault_bit = 4;
   localparam int exp_lp_np_able_bit = 3;
   localparam int exp_np_able_bit = 2;
   localparam int exp_page_rcvd_bit = 1;
   localparam int exp_lp_an_able_bit = 0;

   // ***********************************************
   // Next page transmit fields
   // ***********************************************
   localparam int np_next_bit = 15;
   localparam int np_msg_bit = 13;
   localparam int np_ack2_bit = 12;
   localparam int np_toggle_bit = 11;
   localparam logic [15:0] np_write_mask = 16'hb7ff;
   localparam logic [15:0] np_tx_reset = 16'h2001;
   localparam logic [15:0] np_rx_reset = 16'h0000;

   // ***********************************************
   // Interrupt status fields
   // ***********************************************
   localparam int irq_width = 3;
   localparam int irq_page_bit = 0;
   localparam int irq_fault_bit = 1;
   localparam int irq_np_sent_bit = 2;
   localparam logic [2:0] irq_reset = 3'h0;
endpackage
`default_nettype wire

// File: verilog/latch_flag.sv
`timescale 1ns/10ps
`default_nettype none
module latch_flag (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set,
   input wire logic rd_clr,
   output logic flag
);
   // Latch high; a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag <= 1'b0;
      end else begin
         flag <= set | (flag & ~rd_clr);
      end
   end
endmodule
`default_nettype wire

// File: verilog/phy_autoneg_page_registers.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RULE1 - Partner ability bit 7 is read only, resets to 0, and shows remote 100BASE-X half duplex.
// RULE2 - Partner ability bits 6 and 5 are read only, reset to 0, and show remote 10BASE-T FD/HD.
// RULE3 - Partner selector bits 4:0 are read only and reset to 00001b for IEEE 802.3.
// RULE4 - Expansion bit 6 is read only and always reads 1.
// RULE5 - Expansion bit 5 reads 1 and received next pages land in the receive register at index 8.
// RULE6 - Expansion bit 4 latches high on a parallel detection fault and resets to 0.
// RULE7 - Expansion bit 3 is read only, resets to 0, and shows partner next page ability.
// RULE8 - Expansion bit 2 is read only and reads 1 for local next page ability.
// RULE9 - Expansion bit 1 latches high whenever a new page is received and resets to 0.
// RULE10 - Expansion bit 0 is read only, resets to 0, and shows partner auto-negotiation ability.
// RULE11 - Transmit bit 15 is writable, resets to 0, and flags that more next pages follow.
// RULE12 - Transmit bit 13 is writable resetting to 1; code bits 10:0 are writable resetting to 1.
// RULE13 - Transmit bit 12 is writable, resets to 0, and says whether the device will comply.
// RULE14 - Transmit bit 11 is read only, resets to 0, and shows the toggle state.
// RULE15 - Latched expansion flags hold until a read, which clears them unless still active.
// RULE16 - The toggle inverts on each next page sent, starting opposite the base page toggle.
module phy_autoneg_page_registers #(
   parameter int addr_w = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [addr_w-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic base_page_valid,
   input wire logic [15:0] base_page_word,
   input wire logic next_page_valid,
   input wire logic [15:0] next_page_word,
   input wire logic partner_an_able,
   input wire logic parallel_fault,
   input wire logic an_restart,
   input wire logic base_page_toggle,
   input wire logic np_sent,
   output logic [15:0] np_tx_word,
   output logic np_loaded,
   output logic irq
);

   // ***********************************************
   // Parameter check
   // ***********************************************
   generate
      if (addr_w < 8) begin : g_bad_addr
         $error("addr_w must be at least 8");
      end
   endgenerate

   // ***********************************************
   // Bus decode
   // ***********************************************
   logic [5:0] index;
   logic setup_rd;
   logic access;
   logic wr_done;
   logic rd_done;
   logic mapped;
   logic exp_rd_done;
   logic [15:0] wmask;

   // Word index from byte address
   assign index = paddr[7:2];
   assign setup_rd = psel & ~penable & ~pwrite;
   assign access = psel & penable;
   assign wr_done = access & pwrite & mapped;
   assign rd_done = setup_rd & mapped;
   // Clear where the flags are captured, so an event in the setup cycle is never lost
   assign exp_rd_done = rd_done & (index == an_regs_pkg::idx_autoneg_expansion_status);
   assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // Mapped registers; upper address bits must be zero
   always_comb begin
      mapped = 1'b0;
      if (paddr[1:0] == 2'h0 && (paddr >> 8) == '0) begin
         case (index)
            an_regs_pkg::idx_partner_base_page_ability: mapped = 1'b1;
            an_regs_pkg::idx_autoneg_expansion_status: mapped = 1'b1;
            an_regs_pkg::idx_next_page_transmit: mapped = 1'b1;
            an_regs_pkg::idx_next_page_receive: mapped = 1'b1;
            an_regs_pkg::idx_irq_status: mapped = 1'b1;
            an_regs_pkg::idx_irq_mask: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   end

   // Zero wait states; error on unmapped access
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // ***********************************************
   // Partner base page and received next page
   // ***********************************************
   logic [7:0] partner_ability;
   logic partner_np_able;
   logic [15:0] np_receive;

   // Capture low half of partner base page
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         partner_ability <= an_regs_pkg::lp_ability_reset; // RULE3
         partner_np_able <= 1'b0;
      end else if (base_page_valid) begin
         partner_ability <= base_page_word[7:0]; // RULE1 RULE2 RULE3
         partner_np_able <= base_page_word[an_regs_pkg::lp_np_bit]; // RULE7
      end
   end

   // Next pages stored apart from the base page
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         np_receive <= an_regs_pkg::np_rx_reset;
      end else if (next_page_valid) begin
         np_receive <= next_page_word; // RULE5
      end
   end

   // ***********************************************
   // Latched expansion flags
   // ***********************************************
   logic page_event;
   logic fault_flag;
   logic page_flag;

   assign page_event = base_page_valid | next_page_valid;

   // Parallel detection fault
   latch_flag u_fault_flag (
      .pclk(pclk),
      .presetn(presetn),
      .set(parallel_fault), // RULE6 RULE15
      .rd_clr(exp_rd_done),
      .flag(fault_flag)
   );

   // New page received
   latch_flag u_page_flag (
      .pclk(pclk),
      .presetn(presetn),
      .set(page_event), // RULE9 RULE15
      .rd_clr(exp_rd_done),
      .flag(page_flag)
   );

   // ***********************************************
   // Next page transmit register
   // ***********************************************
   logic [15:0] np_tx;
   logic toggle;
   logic np_wr;

   assign np_wr = wr_done & (index == an_regs_pkg::idx_next_page_transmit);

   // Writable fields; toggle and reserved bits untouched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         np_tx <= an_regs_pkg::np_tx_reset; // RULE11 RULE12 RULE13
      end else if (np_wr) begin
         np_tx <= (np_tx & ~(wmask & an_regs_pkg::np_write_mask))
                  | (pwdata[15:0] & wmask & an_regs_pkg::np_write_mask); // RULE11 RULE12 RULE13
      end
   end

   // Toggle starts opposite base page, flips per page sent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toggle <= 1'b0; // RULE14
      end else if (an_restart) begin
         toggle <= ~base_page_toggle; // RULE16
      end else if (np_sent) begin
         toggle <= ~toggle; // RULE16
      end
   end

   // Page loaded by software, consumed when sent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         np_loaded <= 1'b0;
      end else if (np_wr) begin
         np_loaded <= 1'b1;
      end else if (np_sent | an_restart) begin
         np_loaded <= 1'b0;
      end
   end

   // Word offered to the link
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         np_tx_word <= an_regs_pkg::np_tx_reset;
      end else begin
         np_tx_word <= {np_tx[15:12], toggle, np_tx[10:0]}; // RULE14
      end
   end

   // ***********************************************
   // Interrupts
   // ***********************************************
   logic [an_regs_pkg::irq_width-1:0] irq_status;
   logic [an_regs_pkg::irq_width-1:0] irq_mask;
   logic [an_regs_pkg::irq_width-1:0] irq_set;
   logic [an_regs_pkg::irq_width-1:0] irq_clr;

   assign irq_set = {np_sent, parallel_fault, page_event};
   assign irq_clr = (wr_done && index == an_regs_pkg::idx_irq_status && pstrb[0])
                    ? pwdata[an_regs_pkg::irq_width-1:0] : '0;

   // Sticky status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= an_regs_pkg::irq_reset;
      end else begin
         irq_status <= irq_set | (irq_status & ~irq_clr);
      end
   end

   // Mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= an_regs_pkg::irq_reset;
      end else if (wr_done && index == an_regs_pkg::idx_irq_mask && pstrb[0]) begin
         irq_mask <= pwdata[an_regs_pkg::irq_width-1:0];
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ***********************************************
   // Read path
   // ***********************************************
   logic [15:0] exp_value;
   logic [15:0] rd_value;

   // Expansion register assembly
   always_comb begin
      exp_value = 16'h0000;
      exp_value[an_regs_pkg::exp_loc_able_bit] = 1'b1; // RULE4
      exp_value[an_regs_pkg::exp_loc_store_bit] = 1'b1; // RULE5
      exp_value[an_regs_pkg::exp_pd_fault_bit] = fault_flag; // RULE6
      exp_value[an_regs_pkg::exp_lp_np_able_bit] = partner_np_able; // RULE7
      exp_value[an_regs_pkg::exp_np_able_bit] = 1'b1; // RULE8
      exp_value[an_regs_pkg::exp_page_rcvd_bit] = page_flag; // RULE9
      exp_value[an_regs_pkg::exp_lp_an_able_bit] = partner_an_able; // RULE10
   end

   // Register select
   always_comb begin
      rd_value = 16'h0000;
      case (index)
         an_regs_pkg::idx_partner_base_page_ability: rd_value = {8'h00, partner_ability};
         an_regs_pkg::idx_autoneg_expansion_status: rd_value = exp_value;
         an_regs_pkg::idx_next_page_transmit: rd_value = {np_tx[15:12], toggle, np_tx[10:0]};
         an_regs_pkg::idx_next_page_receive: rd_value = np_receive;
         an_regs_pkg::idx_irq_status: rd_value = {13'h0000, irq_status};
         an_regs_pkg::idx_irq_mask: rd_value = {13'h0000, irq_mask};
         default: rd_value = 16'h0000;
      endcase
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata <= mapped ? {16'h0000, rd_value} : 32'h0000_0000;
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   a_ability_capture: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      base_page_valid |=> partner_ability[an_regs_pkg::lp_hd100_bit]
                          == $past(base_page_word[an_regs_pkg::lp_hd100_bit]))
      else $error("100BASE-X half duplex bit not captured");

   a_ability_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      !base_page_valid ##1 (access && pwrite) |-> $stable(partner_ability))
      else $error("partner ability changed without a page");

   a_selector_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      (setup_rd && mapped && index == an_regs_pkg::idx_partner_base_page_ability)
      |=> prdata[7:0] == $past(partner_ability) && prdata[15:8] == 8'h00)
      else $error("partner ability read mismatch");

   a_loc_able: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      (setup_rd && mapped && index == an_regs_pkg::idx_autoneg_expansion_status)
      |=> prdata[an_regs_pkg::exp_loc_able_bit] && prdata[an_regs_pkg::exp_np_able_bit])
      else $error("fixed expansion bits not one");

   a_np_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
      next_page_valid && !base_page_valid |=> np_receive == $past(next_page_word)
                          && $stable(partner_ability))
      else $error("next page not stored in receive register");

   a_fault_latch: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
      parallel_fault |=> fault_flag [*1] ##0 exp_value[an_regs_pkg::exp_pd_fault_bit])
      else $error("parallel fault not latched");

   a_page_latch: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
      page_event |=> page_flag && irq_status[an_regs_pkg::irq_page_bit])
      else $error("page received not latched");

   a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
      page_flag && !exp_rd_done |=> page_flag)
      else $error("page flag lost before read");

   a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
      exp_rd_done && !parallel_fault |=> !fault_flag)
      else $error("fault flag not cleared by read");

   a_partner_np: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      base_page_valid |=> exp_value[an_regs_pkg::exp_lp_np_able_bit]
                          == $past(base_page_word[an_regs_pkg::lp_np_bit]))
      else $error("partner next page ability mismatch");

   a_np_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
      (np_wr && pstrb[1:0] == 2'b11)
      |=> np_tx[15:12] == {$past(pwdata[15]), 1'b0, $past(pwdata[13:12])}
          && np_tx[10:0] == $past(pwdata[10:0]))
      else $error("next page transmit write mismatch");

   a_toggle_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
      an_restart ##1 !an_restart && np_sent |=> toggle == $past(base_page_toggle, 2))
      else $error("toggle did not start opposite and flip");

   a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
      np_sent && !an_restart |=> toggle != $past(toggle) ##1 np_tx_word[11] == $past(toggle))
      else $error("toggle not inverted per next page");

   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      np_sent |=> irq_status[an_regs_pkg::irq_np_sent_bit]
                  && (irq || !irq_mask[an_regs_pkg::irq_np_sent_bit]))
      else $error("next page sent event gave no interrupt");

endmodule
`default_nettype wire

// File: verification/link_partner_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************
// Far end of the link: page and ability source
// ************************************************
module link_partner_model (
   input wire logic pclk,
   output logic base_page_valid,
   output logic [15:0] base_page_word,
   output logic next_page_valid,
   output logic [15:0] next_page_word,
   output logic partner_an_able
);
   // Quiet link at time zero
   initial begin
      base_page_valid = 1'b0;
      next_page_valid = 1'b0;
      base_page_word = 16'h0000;
      next_page_word = 16'h0000;
      partner_an_able = 1'b0;
   end

   // One base page; word scrambled once the pulse ends
   task automatic send_base(input logic [15:0] w);
      @(posedge pclk);
      base_page_valid <= 1'b1;
      base_page_word <= w;
      @(posedge pclk);
      base_page_valid <= 1'b0;
      base_page_word <= ~w;
   endtask

   // One next page, meant for the receive register
   task automatic send_next(input logic [15:0] w);
      @(posedge pclk);
      next_page_valid <= 1'b1;
      next_page_word <= w;
      @(posedge pclk);
      next_page_valid <= 1'b0;
      next_page_word <= ~w;
   endtask

   // Partner negotiation ability level
   task automatic set_able(input logic a);
      @(posedge pclk);
      partner_an_able <= a;
   endtask
endmodule
`default_nettype wire

// File: verification/phy_autoneg_page_registers_bench.sv
`timescale 1ns/10ps
`default_nettype none
module phy_autoneg_page_registers_bench;
   // ************************************************
   // Stimulus signals and bookkeeping
   // ************************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic parallel_fault = 1'b0;
   logic an_restart = 1'b0;
   logic base_page_toggle = 1'b0;
   logic np_sent = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, np_loaded, irq;
   logic base_page_valid, next_page_valid, partner_an_able;
   logic [15:0] base_page_word, next_page_word, np_tx_word;
   int fails = 0;
   int num_checks = 0;
   int seed = 70;
   logic [33:0] notes[$];
   logic [33:0] note;
   logic [15:0] np_val, r, b;

   // Free running 100 MHz clock
   always #5 pclk = ~pclk;

   phy_autoneg_page_registers #(.addr_w(8)) phy_autoneg_page_registers_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .base_page_valid(base_page_valid), .base_page_word(base_page_word),
      .next_page_valid(next_page_valid), .next_page_word(next_page_word),
      .partner_an_able(partner_an_able), .parallel_fault(parallel_fault),
      .an_restart(an_restart), .base_page_toggle(base_page_toggle), .np_sent(np_sent),
      .np_tx_word(np_tx_word), .np_loaded(np_loaded), .irq(irq));

   link_partner_model link_partner_model_i (
      .pclk(pclk), .base_page_valid(base_page_valid), .base_page_word(base_page_word),
      .next_page_valid(next_page_valid), .next_page_word(next_page_word),
      .partner_an_able(partner_an_able));

   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One APB transfer; expected answer noted for the monitor
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s, input logic [31:0] exp, input logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      pstrb <= s;
      notes.push_back({~w, err, exp});
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         fails++;
         finish_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 16'h0000, 4'hf, exp, 1'b0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
      apb(1'b1, a, d, s, 32'h0, 1'b0);
   endtask

   task automatic pulse_sent(input logic restart);
      @(posedge pclk);
      an_restart <= restart;
      np_sent <= ~restart;
      @(posedge pclk);
      an_restart <= 1'b0;
      np_sent <= 1'b0;
   endtask

   // Completed transfers compared with the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         note = notes.pop_front();
         check("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
         if (note[33]) check("prdata", note[31:0], prdata);
      end
   end

   // Hang guard
   initial begin
      #500000;
      fails++;
      finish_test();
   end

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      check("np_tx_word", 32'h2001, {16'h0, np_tx_word});
      rd(8'h14, 32'h0001);
      rd(8'h18, 32'h0064);
      rd(8'h1c, 32'h2001);
      rd(8'h20, 32'h0000);
      rd(8'h80, 32'h0000);
      rd(8'h84, 32'h0000);
      // Read-only places keep their values
      wr(8'h14, 16'hffff, 4'hf);
      wr(8'h18, 16'hffff, 4'hf);
      wr(8'h20, 16'hffff, 4'hf);
      rd(8'h14, 32'h0001);
      rd(8'h18, 32'h0064);
      rd(8'h20, 32'h0000);
      // Random next page words; reserved and toggle bits ignore writes
      for (int i = 0; i < 4; i++) begin
         r = 16'($random(seed));
         wr(8'h1c, r, 4'h3);
         np_val = r & 16'hb7ff;
         rd(8'h1c, {16'h0, np_val});
         @(negedge pclk);
         check("np_tx_word", {16'h0, np_val}, {16'h0, np_tx_word});
         check("np_loaded", 32'h1, {31'h0, np_loaded});
      end
      wr(8'h1c, 16'h0000, 4'h2);
      wr(8'h1c, 16'hffff, 4'h1);
      np_val = {8'h00, 8'hff};
      rd(8'h1c, {16'h0, np_val});
      // Base page then next page from the partner
      link_partner_model_i.set_able(1'b1);
      b = 16'($random(seed)) | 16'h8000;
      link_partner_model_i.send_base(b);
      rd(8'h14, {24'h0, b[7:0]});
      rd(8'h18, 32'h006f);
      rd(8'h18, 32'h006d);
      r = 16'($random(seed));
      link_partner_model_i.send_next(r);
      rd(8'h20, {16'h0, r});
      rd(8'h14, {24'h0, b[7:0]});
      rd(8'h18, 32'h006f);
      rd(8'h18, 32'h006d);
      // Parallel detection fault, pulsed then held
      @(posedge pclk);
      parallel_fault <= 1'b1;
      @(posedge pclk);
      parallel_fault <= 1'b0;
      rd(8'h18, 32'h007d);
      rd(8'h18, 32'h006d);
      @(posedge pclk);
      parallel_fault <= 1'b1;
      rd(8'h18, 32'h007d);
      rd(8'h18, 32'h007d);
      @(posedge pclk);
      parallel_fault <= 1'b0;
      rd(8'h18, 32'h007d);
      rd(8'h18, 32'h006d);
      // Toggle across restart and sent pages
      base_page_toggle <= 1'b1;
      pulse_sent(1'b1);
      @(negedge pclk);
      check("np_loaded", 32'h0, {31'h0, np_loaded});
      rd(8'h1c, {16'h0, np_val});
      for (int i = 0; i < 3; i++) begin
         pulse_sent(1'b0);
         np_val[11] = ~np_val[11];
         rd(8'h1c, {16'h0, np_val});
      end
      @(negedge pclk);
      check("np_tx_word", {16'h0, np_val}, {16'h0, np_tx_word});
      @(posedge pclk);
      base_page_toggle <= 1'b0;
      pulse_sent(1'b1);
      np_val[11] = 1'b1;
      rd(8'h1c, {16'h0, np_val});
      // Restart then a sent page in the very next cycle
      @(posedge pclk);
      an_restart <= 1'b1;
      @(posedge pclk);
      an_restart <= 1'b0;
      np_sent <= 1'b1;
      @(posedge pclk);
      np_sent <= 1'b0;
      np_val[11] = 1'b0;
      rd(8'h1c, {16'h0, np_val});
      // Interrupt status, mask and clear
      rd(8'h80, 32'h0007);
      check("irq", 32'h0, {31'h0, irq});
      wr(8'h84, 16'h0001, 4'h1);
      @(negedge pclk);
      check("irq", 32'h1, {31'h0, irq});
      wr(8'h80, 16'h0001, 4'h1);
      @(negedge pclk);
      check("irq", 32'h0, {31'h0, irq});
      rd(8'h80, 32'h0006);
      wr(8'h84, 16'h0007, 4'h1);
      @(negedge pclk);
      check("irq", 32'h1, {31'h0, irq});
      wr(8'h80, 16'h0006, 4'h1);
      @(negedge pclk);
      check("irq", 32'h0, {31'h0, irq});
      rd(8'h80, 32'h0000);
      link_partner_model_i.send_next(16'h1234);
      @(negedge pclk);
      check("irq", 32'h1, {31'h0, irq});
      // Unmapped and misaligned accesses
      apb(1'b0, 8'h40, 16'h0000, 4'hf, 32'h0, 1'b1);
      apb(1'b0, 8'h19, 16'h0000, 4'hf, 32'h0, 1'b1);
      apb(1'b1, 8'h44, 16'hffff, 4'hf, 32'h0, 1'b1);
      repeat (3) @(posedge pclk);
      finish_test();
   end
endmodule
`default_nettype wire
